/* core/cps_pkg.sv */
// constants for the color processing state field holder
package cps_pkg;

  // word indices of the held state words; byte address is four times the index
  localparam logic [5:0] CPS_IDX_FIRST      = 6'h1D; // contrast enable word (29)
  localparam logic [5:0] CPS_IDX_LUMA       = 6'h1E; // luma points 0..3 (30)
  localparam logic [5:0] CPS_IDX_BIAS       = 6'h21; // biases 1..4 (33)
  localparam logic [5:0] CPS_IDX_SLOPE      = 6'h24; // slopes 0,1 (36)
  localparam logic [5:0] CPS_IDX_SAT        = 6'h2A; // saturation 1..3, enable (42)
  localparam logic [5:0] CPS_IDX_BASE       = 6'h2C; // base colors 1..3 (44)
  localparam logic [5:0] CPS_IDX_TRANSIT    = 6'h2E; // transit slopes 12,23 (46)
  localparam logic [5:0] CPS_IDX_CBIAS      = 6'h31; // color biases 1..3 (49)
  localparam logic [5:0] CPS_IDX_CHROMA_THR = 6'h33; // chroma and skin thresholds (51)
  localparam logic [5:0] CPS_IDX_MAX_CHROMA = 6'h34; // max chroma color (52)
  localparam logic [5:0] CPS_IDX_BRIGHT     = 6'h35; // brightness and contrast (53)
  localparam logic [5:0] CPS_IDX_HUE        = 6'h36; // hue rotation (54)
  localparam logic [5:0] CPS_IDX_LAST       = 6'h37; // transform coefficients 0,1 (55)
  localparam int         CPS_NUM_WORDS      = 27;

  // field positions
  localparam int CPS_POS_ODD_SLOPE    = 16;
  localparam int CPS_POS_SAT_FACTOR   = 8;
  localparam int CPS_POS_TCC_ENABLE   = 7;
  localparam int CPS_POS_COLOR_BIAS   = 2;
  localparam int CPS_POS_CHROMA_THR   = 24;
  localparam int CPS_POS_CHROMA_BITS  = 16;
  localparam int CPS_POS_SKIN_THR     = 8;
  localparam int CPS_POS_SKIN_SLOPE   = 0;
  localparam int CPS_POS_INV_MAX      = 16;
  localparam int CPS_POS_CONTRAST     = 17;
  localparam int CPS_POS_BRIGHTNESS   = 1;
  localparam int CPS_POS_ADJ_ENABLE   = 0;
  localparam int CPS_POS_HUE_COS      = 16;
  localparam int CPS_POS_COEF1        = 16;
  localparam int CPS_POS_COEF0        = 3;

  // reset contents, word 55 first down to word 29
  localparam logic [CPS_NUM_WORDS-1:0][31:0] CPS_WORD_RESET = {
    32'h00002000, 32'h01000000, 32'h00020001, 32'h009201C0, 32'h03030000,
    32'h00000000, 32'h00096000, 32'h01790174, 32'h0197046B, 32'h02E80195,
    32'h3E3CCE91, 32'h1E34CC91, 32'hDCDCDC00, 32'hDCDCDC00, 32'h00000400,
    32'h04000400, 32'h04000400, 32'h04000400, 32'h04000400, 32'h04000400,
    32'h0000D8C4, 32'hB09C8874, 32'h604C3824, 32'hEBD8C4B0, 32'h9C887460,
    32'h4C382410, 32'h00000000};

  // bits that hold fields; all others are reserved and stored as zero
  localparam logic [CPS_NUM_WORDS-1:0][31:0] CPS_WORD_MASK = {
    32'h1FFFFFF8, 32'hFFFFFFFF, 32'h0FFE1FFF, 32'hFFFF01FF, 32'h7F071F07,
    32'hFFFFFFFC, 32'hFFFFFFFC, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'h3FFFFFFF, 32'h3FFFFFFF, 32'hFFFFFF00, 32'hFFFFFF80, 32'h000007FF,
    32'h07FF07FF, 32'h07FF07FF, 32'h07FF07FF, 32'h07FF07FF, 32'h07FF07FF,
    32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'hFFFFFFFF, 32'h00000001};

  localparam logic [31:0] CPS_READ_UNMAPPED = 32'h00000000;

  typedef struct packed {
    logic [CPS_NUM_WORDS-1:0][31:0] words;
    logic [31:0]                    rd_data;
    logic [5:0]                     next_idx;
    logic                           state_valid;
  } cps_state_t;

endpackage : cps_pkg

/* core/cps_state_fields.sv */
// holder and decoder for contrast, color control, adjust and transform state
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cps_state_fields (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  // register port
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [31:0]        o_rdata,
  // load status
  output logic                    o_state_valid,
  // adaptive contrast
  output logic                    o_adaptive_contrast_en,
  output logic      [11:0][7:0]   o_luma_point,
  output logic      [9:0][7:0]    o_luma_bias,
  output logic      [10:0][10:0]  o_luma_slope,
  // total color control
  output logic                    o_total_color_control_en,
  output logic      [5:0][7:0]    o_saturation_factor,
  output logic      [5:0][9:0]    o_base_color,
  output logic      [5:0][15:0]   o_transit_slope,
  output logic      [5:0][9:0]    o_color_bias,
  output logic      [6:0]         o_chroma_threshold,
  output logic      [2:0]         o_chroma_width_bits,
  output logic      [4:0]         o_skin_tone_enhance_threshold,
  output logic      [2:0]         o_skin_tone_enhance_slope_bits,
  output logic      [8:0]         o_max_chroma_color,
  output logic      [15:0]        o_inv_max_chroma_color,
  // brightness and contrast adjust
  output logic                    o_brightness_contrast_adjust_en,
  output logic      [10:0]        o_contrast,
  output logic      [11:0]        o_brightness,
  output logic      [15:0]        o_hue_cos,
  output logic      [15:0]        o_hue_sin,
  // color space transform
  output logic      [12:0]        o_color_space_transform_coef0,
  output logic      [12:0]        o_color_space_transform_coef1
);

  cps_pkg::cps_state_t state_q;
  cps_pkg::cps_state_t state_d;

  logic [5:0] acc_idx;
  logic       acc_hit;
  logic [4:0] acc_slot;

  // position of a word index within the held array
  function automatic logic [4:0] slot_of(input logic [5:0] idx);
    logic [5:0] diff;
    diff = idx - cps_pkg::CPS_IDX_FIRST;
    return diff[4:0];
  endfunction

  // fetch a held word by its index
  function automatic logic [31:0] word_at(input cps_pkg::cps_state_t s,
                                          input logic [5:0] idx);
    return s.words[slot_of(idx)];
  endfunction

  assign acc_idx  = i_addr[7:2];
  assign acc_slot = slot_of(acc_idx);
  assign acc_hit  = (i_addr[1:0] == 2'h0) &&
                    (acc_idx >= cps_pkg::CPS_IDX_FIRST) &&
                    (acc_idx <= cps_pkg::CPS_IDX_LAST);

  always_comb begin
    state_d = state_q;
    state_d.rd_data = cps_pkg::CPS_READ_UNMAPPED;
    if (i_rd && acc_hit) begin
      state_d.rd_data = state_q.words[acc_slot];
    end
    if (i_wr && acc_hit) begin
      // reserved bits are dropped so they always read back as zero
      state_d.words[acc_slot] = i_wdata & cps_pkg::CPS_WORD_MASK[acc_slot];
      // a pass starts at the first word; any skip voids it until restarted
      if (acc_idx == cps_pkg::CPS_IDX_FIRST) begin
        state_d.next_idx    = acc_idx + 6'h01;
        state_d.state_valid = 1'b0;
      end else if (acc_idx == state_q.next_idx) begin
        state_d.next_idx    = acc_idx + 6'h01;
        state_d.state_valid = (acc_idx == cps_pkg::CPS_IDX_LAST);
      end else begin
        state_d.next_idx    = cps_pkg::CPS_IDX_FIRST;
        state_d.state_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      // reset contents are the documented defaults, so they count as loaded
      state_q.words       <= cps_pkg::CPS_WORD_RESET;
      state_q.rd_data     <= cps_pkg::CPS_READ_UNMAPPED;
      state_q.next_idx    <= cps_pkg::CPS_IDX_FIRST;
      state_q.state_valid <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rdata       = state_q.rd_data;
  assign o_state_valid = state_q.state_valid;

  // adaptive contrast curve
  assign o_adaptive_contrast_en = state_q.words[0][0];

  always_comb begin
    for (int p = 0; p < 12; p++) begin
      o_luma_point[p] = state_q.words[slot_of(cps_pkg::CPS_IDX_LUMA) + 5'(p / 4)]
                                     [8 * (p % 4) +: 8];
    end
    for (int b = 0; b < 10; b++) begin
      o_luma_bias[b] = state_q.words[slot_of(cps_pkg::CPS_IDX_BIAS) + 5'(b / 4)]
                                    [8 * (b % 4) +: 8];
    end
    for (int s = 0; s < 11; s++) begin
      o_luma_slope[s] = state_q.words[slot_of(cps_pkg::CPS_IDX_SLOPE) + 5'(s / 2)]
                                     [cps_pkg::CPS_POS_ODD_SLOPE * (s % 2) +: 11];
    end
  end

  // total color control
  assign o_total_color_control_en =
    word_at(state_q, cps_pkg::CPS_IDX_SAT)[cps_pkg::CPS_POS_TCC_ENABLE];

  always_comb begin
    for (int k = 0; k < 6; k++) begin
      // factors 1..3 and 4..6 sit in the same lanes of two words
      o_saturation_factor[k] = state_q.words[slot_of(cps_pkg::CPS_IDX_SAT) + 5'(k / 3)]
                                 [cps_pkg::CPS_POS_SAT_FACTOR + 8 * (k % 3) +: 8];
      o_base_color[k]        = state_q.words[slot_of(cps_pkg::CPS_IDX_BASE) + 5'(k / 3)]
                                 [10 * (k % 3) +: 10];
      // entry k is the slope from color k+1 to the next, the last wraps to 1
      o_transit_slope[k]     = state_q.words[slot_of(cps_pkg::CPS_IDX_TRANSIT) + 5'(k / 2)]
                                 [16 * (k % 2) +: 16];
      o_color_bias[k]        = state_q.words[slot_of(cps_pkg::CPS_IDX_CBIAS) + 5'(k / 3)]
                                 [cps_pkg::CPS_POS_COLOR_BIAS + 10 * (k % 3) +: 10];
    end
  end

  assign o_chroma_threshold =
    word_at(state_q, cps_pkg::CPS_IDX_CHROMA_THR)[cps_pkg::CPS_POS_CHROMA_THR +: 7];
  assign o_chroma_width_bits =
    word_at(state_q, cps_pkg::CPS_IDX_CHROMA_THR)[cps_pkg::CPS_POS_CHROMA_BITS +: 3];
  assign o_skin_tone_enhance_threshold =
    word_at(state_q, cps_pkg::CPS_IDX_CHROMA_THR)[cps_pkg::CPS_POS_SKIN_THR +: 5];
  assign o_skin_tone_enhance_slope_bits =
    word_at(state_q, cps_pkg::CPS_IDX_CHROMA_THR)[cps_pkg::CPS_POS_SKIN_SLOPE +: 3];
  // reciprocal is supplied by software; nothing here checks it against the color
  assign o_max_chroma_color =
    word_at(state_q, cps_pkg::CPS_IDX_MAX_CHROMA)[8:0];
  assign o_inv_max_chroma_color =
    word_at(state_q, cps_pkg::CPS_IDX_MAX_CHROMA)[cps_pkg::CPS_POS_INV_MAX +: 16];

  // brightness, contrast and hue
  assign o_contrast =
    word_at(state_q, cps_pkg::CPS_IDX_BRIGHT)[cps_pkg::CPS_POS_CONTRAST +: 11];
  assign o_brightness =
    word_at(state_q, cps_pkg::CPS_IDX_BRIGHT)[cps_pkg::CPS_POS_BRIGHTNESS +: 12];
  assign o_brightness_contrast_adjust_en =
    word_at(state_q, cps_pkg::CPS_IDX_BRIGHT)[cps_pkg::CPS_POS_ADJ_ENABLE];
  assign o_hue_cos =
    word_at(state_q, cps_pkg::CPS_IDX_HUE)[cps_pkg::CPS_POS_HUE_COS +: 16];
  assign o_hue_sin = word_at(state_q, cps_pkg::CPS_IDX_HUE)[15:0];

  // color space transform
  assign o_color_space_transform_coef0 =
    word_at(state_q, cps_pkg::CPS_IDX_LAST)[cps_pkg::CPS_POS_COEF0 +: 13];
  assign o_color_space_transform_coef1 =
    word_at(state_q, cps_pkg::CPS_IDX_LAST)[cps_pkg::CPS_POS_COEF1 +: 13];

endmodule // cps_state_fields

`default_nettype wire

/* tb/cps_state_fields_sva.sv */
// assertion checker for the state field holder
`timescale 1ns/1ps
`default_nettype none
module cps_state_fields_sva (
  input wire logic              i_clk,
  input wire logic              i_reset,
  input wire logic [7:0]        i_addr,
  input wire logic [31:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_state_valid,
  input wire logic [11:0][7:0]  o_luma_point,
  input wire logic [10:0][10:0] o_luma_slope,
  input wire logic [5:0][7:0]   o_saturation_factor,
  input wire logic [6:0]        o_chroma_threshold,
  input wire logic [10:0]       o_contrast,
  input wire logic [15:0]       o_hue_cos,
  input wire logic [12:0]       o_color_space_transform_coef0
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence wr_at(logic [7:0] a); i_wr && i_addr == a; endsequence
  sequence rd_at(logic [7:0] a); i_rd && i_addr == a; endsequence
  luma_point_a: assert property (
    wr_at(8'h78) |=> o_luma_point[0] == $past(i_wdata[7:0])) else $error("luma point bad");
  slope_pack_a: assert property (
    wr_at(8'h90) |=> o_luma_slope[1] == $past(i_wdata[26:16])
      && o_luma_slope[0] == $past(i_wdata[10:0])) else $error("slope packing bad");
  sat_factor_a: assert property (
    wr_at(8'hA8) |=> o_saturation_factor[0] == $past(i_wdata[15:8])) else $error("sat bad");
  chroma_thr_a: assert property (
    wr_at(8'hCC) |=> o_chroma_threshold == $past(i_wdata[30:24])) else $error("thr bad");
  contrast_a: assert property (
    wr_at(8'hD4) |=> o_contrast == $past(i_wdata[27:17])) else $error("contrast bad");
  hue_cos_a: assert property (
    wr_at(8'hD8) |=> o_hue_cos == $past(i_wdata[31:16])) else $error("hue bad");
  coef_zero_a: assert property (
    wr_at(8'hDC) |=> o_color_space_transform_coef0 == $past(i_wdata[15:3]))
    else $error("coefficient bad");
  read_back_a: assert property (
    wr_at(8'hD8) ##1 rd_at(8'hD8) |=> o_rdata == $past(i_wdata, 2)) else $error("readback bad");
  read_idle_a: assert property (!i_rd |=> o_rdata == 32'h00000000)
    else $error("read data not idle");
  pass_start_a: assert property (wr_at(8'h74) |=> !o_state_valid)
    else $error("valid kept at pass start");
endmodule // cps_state_fields_sva
`default_nettype wire

/* tb/cps_state_fields_tb.sv */
// testbench for the state field holder
`timescale 1ns/1ps
`default_nettype none
module cps_state_fields_tb;
  logic i_clk, i_reset, tb_wr, tb_rd, go, gap, p_wr, busy, rd_q, o_state_valid;
  logic i_wr, i_rd, o_adaptive_contrast_en, o_total_color_control_en;
  logic o_brightness_contrast_adjust_en;
  logic [7:0] tb_addr, p_addr, i_addr;
  logic [31:0] tb_wdata, p_wdata, i_wdata, o_rdata;
  logic [26:0][31:0] img;
  logic [11:0][7:0] o_luma_point;
  logic [9:0][7:0] o_luma_bias;
  logic [10:0][10:0] o_luma_slope;
  logic [5:0][7:0] o_saturation_factor;
  logic [5:0][9:0] o_base_color, o_color_bias;
  logic [5:0][15:0] o_transit_slope;
  logic [6:0] o_chroma_threshold;
  logic [2:0] o_chroma_width_bits, o_skin_tone_enhance_slope_bits;
  logic [4:0] o_skin_tone_enhance_threshold;
  logic [8:0] o_max_chroma_color;
  logic [15:0] o_inv_max_chroma_color, o_hue_cos, o_hue_sin;
  logic [10:0] o_contrast;
  logic [11:0] o_brightness;
  logic [12:0] o_color_space_transform_coef0, o_color_space_transform_coef1;
  logic [31:0] expq[$];
  int error_cnt, checks, p;
  // bench strobes stay low while the writer model owns the port
  assign i_wr = busy ? p_wr : tb_wr;
  assign i_rd = tb_rd;
  assign i_addr = busy ? p_addr : tb_addr;
  assign i_wdata = busy ? p_wdata : tb_wdata;
  cps_state_fields i_dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_state_valid, .o_adaptive_contrast_en, .o_luma_point, .o_luma_bias, .o_luma_slope,
    .o_total_color_control_en, .o_saturation_factor, .o_base_color, .o_transit_slope,
    .o_color_bias, .o_chroma_threshold, .o_chroma_width_bits, .o_skin_tone_enhance_threshold,
    .o_skin_tone_enhance_slope_bits, .o_max_chroma_color, .o_inv_max_chroma_color,
    .o_brightness_contrast_adjust_en, .o_contrast, .o_brightness, .o_hue_cos, .o_hue_sin,
    .o_color_space_transform_coef0, .o_color_space_transform_coef1);
  cps_sw_writer i_writer (.i_clk, .i_go(go), .i_gap(gap), .i_image(img), .o_addr(p_addr),
    .o_wdata(p_wdata), .o_wr(p_wr), .o_busy(busy));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    tb_wr <= w;
    tb_rd <= !w;
    tb_addr <= a;
    tb_wdata <= d;
    if (!w) expq.push_back(e);
    @(posedge i_clk);
  endtask
  task automatic idle_settle();
    tb_wr <= 1'b0;
    tb_rd <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic load(input logic slow);
    int k;
    gap <= slow;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    for (k = 0; k < 100 && (busy || k < 2); k++) @(posedge i_clk);
    if (busy) begin
      error_cnt++;
      complete_run();
    end
    @(negedge i_clk);
    check("valid", o_state_valid, 1);
    @(posedge i_clk);
  endtask
  task automatic defaults();
    check("valid", o_state_valid, 1);
    check("pt0", o_luma_point[0], 16);
    check("pt11", o_luma_point[11], 235);
    for (p = 1; p <= 10; p++) begin
      check("pt", o_luma_point[p], 16 + 20 * p);
      check("bias", o_luma_bias[p-1], 16 + 20 * p);
    end
    for (p = 0; p <= 10; p++) check("slope", o_luma_slope[p], 1024);
    for (p = 0; p < 6; p++) begin
      check("sat", o_saturation_factor[p], 220);
      check("cbias", o_color_bias[p], p == 1 ? 150 : 0);
    end
    check("transit", o_transit_slope[1], 744);
    check("uv", {o_chroma_threshold, o_chroma_width_bits}, {7'h03, 3'h3});
    check("skin", {o_skin_tone_enhance_threshold, o_skin_tone_enhance_slope_bits}, 0);
    check("maxc", {o_max_chroma_color, o_inv_max_chroma_color}, {9'h1C0, 16'h0092});
    check("adj", {o_contrast, o_brightness, o_brightness_contrast_adjust_en},
      {11'h001, 12'h000, 1'b1});
    check("ace_en", o_adaptive_contrast_en, 0);
    check("tcc_en", o_total_color_control_en, 0);
    check("bc1", o_base_color[0], 145);
    check("bc2", o_base_color[1], 307);
    check("bc3", o_base_color[2], 483);
    check("bc4", o_base_color[3], 657);
    check("bc6", o_base_color[5], 995);
    check("hue", {o_hue_cos, o_hue_sin}, 32'h01000000);
    check("csc", {o_color_space_transform_coef0, o_color_space_transform_coef1},
      {13'h0400, 13'h0000});
  endtask
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) rd_q <= i_rd;
  always @(negedge i_clk) if (rd_q) check("rdata", o_rdata, expq.pop_front());
  initial begin
    {i_reset, tb_wr, tb_rd, go, gap, tb_addr, tb_wdata} = {1'b1, 44'h0};
    void'($urandom(32'h15D875E2));
    for (p = 0; p < 27; p++) img[p] = $urandom;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    defaults();
    @(posedge i_clk);
    load(1'b1);
    for (p = 0; p < 27; p++) bus(0, 8'(4 * (p + 29)), 0, img[p] & cps_pkg::CPS_WORD_MASK[p]);
    bus(0, 8'h00, 0, 0);
    bus(0, 8'hE0, 0, 0);
    bus(0, 8'h79, 0, 0);
    // out-of-order write lands on a word the slope check below does not read
    bus(1, 8'hD0, $urandom, 0);
    idle_settle();
    check("order", o_state_valid, 0);
    for (p = 0; p <= 10; p++)
      check("pack", o_luma_slope[p], p % 2 ? img[7+p/2][26:16] : img[7+p/2][10:0]);
    @(posedge i_clk);
    load(1'b0);
    bus(1, 8'hD8, img[3], 0);
    bus(0, 8'hD8, 0, img[3]);
    bus(1, 8'h74, 32'h00000001, 0);
    idle_settle();
    check("restart", o_state_valid, 0);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(negedge i_clk);
    defaults();
    repeat (2) @(posedge i_clk);
    complete_run();
  end
endmodule // cps_state_fields_tb
bind cps_state_fields cps_state_fields_sva i_sva (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .o_state_valid, .o_luma_point, .o_luma_slope, .o_saturation_factor,
  .o_chroma_threshold, .o_contrast, .o_hue_cos, .o_color_space_transform_coef0);
`default_nettype wire

/* tb/cps_sw_writer.sv */
// software side model: writes the state words in order
`timescale 1ns/1ps
`default_nettype none
module cps_sw_writer (
  input  wire logic                                    i_clk,
  input  wire logic                                    i_go,
  input  wire logic                                    i_gap,
  input  wire logic [cps_pkg::CPS_NUM_WORDS-1:0][31:0] i_image,
  output logic      [7:0]                              o_addr,
  output logic      [31:0]                             o_wdata,
  output logic                                         o_wr,
  output logic                                         o_busy
);
  int n;
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h00000000;
    o_wr = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        for (n = 0; n < cps_pkg::CPS_NUM_WORDS; n++) begin
          o_addr <= 8'(4 * (n + 29));
          o_wdata <= i_image[n] & cps_pkg::CPS_WORD_MASK[n];
          o_wr <= 1'b1;
          @(posedge i_clk);
          if (i_gap) begin
            o_wr <= 1'b0;
            @(posedge i_clk);
          end
        end
        o_wr <= 1'b0;
        o_busy <= 1'b0;
        // released data must not look like the last word
        o_wdata <= ~o_wdata;
      end
    end
  end
endmodule // cps_sw_writer
`default_nettype wire
